/* File: src/fos_pkg.sv */
// fail output signalling: shared constants and mode codes
// assumes a 50 MHz system clock
package fos_pkg;
    localparam int CLK_MHZ = 50;
    // blink period 800 ms (1.25 Hz), half of it per phase
    localparam int BLINK_PERIOD_US = 800000;
    localparam int BLINK_HALF_CYC = BLINK_PERIOD_US * CLK_MHZ / 2;
    // pwm period 10 ms (100 Hz)
    localparam int PWM_PERIOD_US = 10000;
    localparam int PWM_PERIOD_CYC = PWM_PERIOD_US * CLK_MHZ;
    // strap input filter 64 us
    localparam int STRAP_FILT_US = 64;
    localparam int STRAP_FILT_CYC = STRAP_FILT_US * CLK_MHZ;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_SLEEP = 2'h2;
    localparam logic [1:0] MODE_FAILSAFE = 2'h3;
    localparam logic [1:0] CFG_ONE = 2'h0;
    localparam logic [1:0] CFG_TWO = 2'h1;
    localparam logic [1:0] PIN_FO = 2'h0;
    localparam logic [1:0] PIN_WAKE = 2'h1;
    localparam logic [1:0] PIN_LS = 2'h2;
    localparam logic [1:0] PIN_HS = 2'h3;
    localparam logic [1:0] DUTY_20 = 2'h0;
    localparam logic [1:0] DUTY_10 = 2'h1;
    localparam logic [1:0] DUTY_5 = 2'h2;
    localparam logic [1:0] WD_MAX_CFG2 = 2'h1;
    localparam logic [1:0] WD_MAX_OTHER = 2'h2;
    localparam logic [1:0] WD_THR_EARLY = 2'h1;
    localparam logic [1:0] WD_THR_LATE = 2'h2;
    localparam logic [2:0] UV_LIMIT = 3'h4;
    localparam logic STRAP_RST = 1'b1;
endpackage : fos_pkg

/* File: src/fos_wave_if.sv */
// fail output signalling: waveform request and result between top and generator
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fos_wave_if;
    logic active;
    logic [1:0] duty;
    logic blink_low;
    logic pwm_low;
    modport gen(input active, input duty, output blink_low, output pwm_low);
    modport ctl(output active, output duty, input blink_low, input pwm_low);
endinterface : fos_wave_if
`default_nettype wire

/* File: src/fos_wave_gen.sv */
// fail output signalling: blink and pwm waveform counters
// assumes active is registered; counters restart whenever it drops
`timescale 1ns/1ps
`default_nettype none
module fos_wave_gen
    import fos_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC,
    parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    fos_wave_if.gen w
);
    localparam int BW = $clog2(BLINK_HALF + 1);
    localparam int PW = $clog2(PWM_PERIOD + 1);

    function automatic logic [PW-1:0] on_cycles(input logic [1:0] sel);
        case (sel)
            DUTY_20: on_cycles = PW'(PWM_PERIOD / 5);
            DUTY_10: on_cycles = PW'(PWM_PERIOD / 10);
            DUTY_5: on_cycles = PW'(PWM_PERIOD / 20);
            default: on_cycles = PW'(PWM_PERIOD / 40);
        endcase
    endfunction : on_cycles

    logic [BW-1:0] blink_cnt, next_blink_cnt;
    logic [PW-1:0] pwm_cnt, next_pwm_cnt;
    logic phase, next_phase;

    // restart from zero keeps all three pins starting low together
    always_comb begin
        next_blink_cnt = '0;
        next_phase = 1'b0;
        next_pwm_cnt = '0;
        if (w.active) begin
            next_phase = phase;
            next_blink_cnt = blink_cnt + 1'b1;
            if (blink_cnt == BW'(BLINK_HALF - 1)) begin
                next_blink_cnt = '0;
                next_phase = ~phase;
            end
            next_pwm_cnt = pwm_cnt + 1'b1;
            if (pwm_cnt == PW'(PWM_PERIOD - 1)) begin
                next_pwm_cnt = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blink_cnt <= '0;
            phase <= 1'b0;
            pwm_cnt <= '0;
        end else begin
            blink_cnt <= next_blink_cnt;
            phase <= next_phase;
            pwm_cnt <= next_pwm_cnt;
        end
    end

    assign w.blink_low = w.active & ~phase;
    assign w.pwm_low = w.active & (pwm_cnt < on_cycles(w.duty));
endmodule : fos_wave_gen
`default_nettype wire

/* File: src/fos_strap_filt.sv */
// fail output signalling: strap level filter
// assumes raw input already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module fos_strap_filt
    import fos_pkg::*;
#(
    parameter int FILT_CYC = STRAP_FILT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic raw,
    output logic level
);
    localparam int CW = $clog2(FILT_CYC + 1);
    logic [CW-1:0] cnt, next_cnt;
    logic next_level;

    // a level must stand the whole filter time before it is taken
    always_comb begin
        next_cnt = '0;
        next_level = level;
        if (raw != level) begin
            next_cnt = cnt + 1'b1;
            if (cnt == CW'(FILT_CYC - 1)) begin
                next_cnt = '0;
                next_level = raw;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            level <= STRAP_RST;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end
endmodule : fos_strap_filt
`default_nettype wire

/* File: src/fos_top.sv */
// fail output signalling: fault latch, watchdog error count, pin drivers, gpio
// assumes mode, watchdog and supervision events come from outside as pulses
`timescale 1ns/1ps
`default_nettype none
module fos_top
    import fos_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC,
    parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] sbc_mode,
    input wire logic [1:0] strap_cfg,
    input wire logic wd_trig_fail,
    input wire logic wd_trig_ok,
    input wire logic wd_off_in_stop,
    input wire logic wd_failsafe_en,
    input wire logic thermal_shutdown_level_two,
    input wire logic regulator_short,
    input wire logic regulator_overvoltage,
    input wire logic regulator_overvoltage_reset_en,
    input wire logic undervoltage_event,
    input wire logic undervoltage_run_clear,
    input wire logic force_fail_pins_bit,
    input wire logic [1:0] pwm_duty_select,
    input wire logic failure_flag_clear,
    input wire logic [1:0] blink_pin_func,
    input wire logic [1:0] pwm_pin_func,
    input wire logic [1:0] switch_on,
    input wire logic [1:0] wake_event_clear,
    input wire logic static_fail_pin_in,
    output logic static_fail_pin_out,
    output logic static_fail_pin_oe,
    input wire logic blink_fail_pin_in,
    output logic blink_fail_pin_out,
    output logic blink_fail_pin_oe,
    input wire logic pwm_fail_strap_pin_in,
    output logic pwm_fail_strap_pin_out,
    output logic pwm_fail_strap_pin_oe,
    output logic failure_flag,
    output logic fail_active,
    output logic failsafe_request,
    output logic [1:0] watchdog_error_count,
    output logic [1:0] wake_event_status_two,
    output logic [1:0] wake_level_status,
    output logic strap_level
);
    // returns {out, oe}; fail function pulls low only, switches follow enable
    function automatic logic [1:0] pin_drive(input logic [1:0] func,
                                             input logic fo_low,
                                             input logic sw);
        case (func)
            PIN_FO: pin_drive = {1'b0, fo_low};
            PIN_LS: pin_drive = {1'b0, sw};
            PIN_HS: pin_drive = {1'b1, sw};
            default: pin_drive = 2'b00;
        endcase
    endfunction : pin_drive

    fos_wave_if wave ();

    logic [1:0] mode_d, next_mode_d;
    logic cond_d, next_cond_d;
    logic [2:0] uv_cnt, next_uv_cnt;
    logic wd_caused, next_wd_caused;
    logic latched, next_latched;
    logic [1:0] next_count;
    logic next_flag, next_active, next_failsafe;
    logic nonwd_cond, nonwd_evt, uv_hit, sleep_entry, wd_clear, release_ok;
    logic watchdog_error_count_evt, wd_flag_evt;
    logic [1:0] wd_max, wd_thr, wd_inc;
    logic cfg_early;

    assign cfg_early = (strap_cfg == CFG_ONE) || (strap_cfg == CFG_TWO);

    always_comb begin
        nonwd_cond = thermal_shutdown_level_two | regulator_short
                   | (regulator_overvoltage & regulator_overvoltage_reset_en);
        uv_hit = undervoltage_event && (uv_cnt == UV_LIMIT - 3'h1);
        nonwd_evt = (nonwd_cond & ~cond_d) | uv_hit;
        wd_max = (strap_cfg == CFG_TWO) ? WD_MAX_CFG2 : WD_MAX_OTHER;
        wd_thr = cfg_early ? WD_THR_EARLY : WD_THR_LATE;
        wd_inc = (watchdog_error_count < wd_max) ? watchdog_error_count + 2'h1
                                                  : watchdog_error_count;
        watchdog_error_count_evt = wd_trig_fail && (wd_inc >= wd_thr);
        // configuration two: the first failure drives pins but not the flag
        wd_flag_evt = watchdog_error_count_evt
                    && !(strap_cfg == CFG_TWO && watchdog_error_count == 2'h0);
        sleep_entry = (sbc_mode == MODE_SLEEP) && (mode_d != MODE_SLEEP);
        wd_clear = wd_trig_ok | sleep_entry | nonwd_evt | wd_off_in_stop;
        // a new failure in the same cycle as a clear is kept
        next_count = wd_trig_fail ? wd_inc : (wd_clear ? 2'h0 : watchdog_error_count);
        next_uv_cnt = uv_cnt;
        if (undervoltage_event) begin
            next_uv_cnt = uv_hit ? 3'h0 : uv_cnt + 3'h1;
        end else if (undervoltage_run_clear) begin
            next_uv_cnt = 3'h0;
        end
        next_wd_caused = watchdog_error_count_evt | (wd_caused & (next_count != 2'h0));
        release_ok = (sbc_mode == MODE_NORMAL) && !nonwd_cond && !failure_flag
                   && !wd_caused;
        next_latched = nonwd_cond | nonwd_evt | watchdog_error_count_evt | (latched & ~release_ok);
        next_flag = nonwd_cond | uv_hit | wd_flag_evt
                  | (failure_flag & ~failure_flag_clear);
        next_failsafe = nonwd_evt | (watchdog_error_count_evt & wd_failsafe_en);
        next_active = next_latched | force_fail_pins_bit
                    | (sbc_mode == MODE_FAILSAFE);
        next_mode_d = sbc_mode;
        next_cond_d = nonwd_cond;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_d <= MODE_NORMAL;
            cond_d <= 1'b0;
            uv_cnt <= 3'h0;
            wd_caused <= 1'b0;
            latched <= 1'b0;
            watchdog_error_count <= 2'h0;
            failure_flag <= 1'b0;
            fail_active <= 1'b0;
            failsafe_request <= 1'b0;
        end else begin
            mode_d <= next_mode_d;
            cond_d <= next_cond_d;
            uv_cnt <= next_uv_cnt;
            wd_caused <= next_wd_caused;
            latched <= next_latched;
            watchdog_error_count <= next_count;
            failure_flag <= next_flag;
            fail_active <= next_active;
            failsafe_request <= next_failsafe;
        end
    end

    assign wave.active = fail_active;
    assign wave.duty = pwm_duty_select;

    fos_wave_gen #(
        .BLINK_HALF(BLINK_HALF),
        .PWM_PERIOD(PWM_PERIOD)
    ) u_wave (
        .clk(clk),
        .rst_b(rst_b),
        .w(wave.gen)
    );

    fos_strap_filt #(
        .FILT_CYC(STRAP_FILT_CYC)
    ) u_strap (
        .clk(clk),
        .rst_b(rst_b),
        .raw(pwm_fail_strap_pin_in),
        .level(strap_level)
    );

    // gpio side: index 0 is the blink pin, index 1 the pwm/strap pin
    logic [1:0][1:0] gp_func;
    logic [1:0] gp_in, gp_d, next_gp_d, fo_low, sw_hold, next_sw_hold;
    logic [1:0] next_wake, next_lvl, next_pin_out, next_pin_oe, pin_out, pin_oe;
    logic next_static_oe;
    logic [1:0] drv;
    logic live_mode, wake_mode, sw_mode;

    assign gp_func = {pwm_pin_func, blink_pin_func};
    assign gp_in = {pwm_fail_strap_pin_in, blink_fail_pin_in};
    assign fo_low = {wave.pwm_low, wave.blink_low};

    always_comb begin
        live_mode = (sbc_mode == MODE_NORMAL) || (sbc_mode == MODE_STOP);
        wake_mode = (sbc_mode != MODE_FAILSAFE);
        sw_mode = live_mode;
        // switch setting frozen when leaving normal mode
        next_sw_hold = (sbc_mode == MODE_NORMAL) ? switch_on : sw_hold;
        next_gp_d = gp_in;
        next_static_oe = fail_active;
        next_wake = wake_event_status_two;
        next_lvl = wake_level_status;
        next_pin_out = 2'b00;
        next_pin_oe = 2'b00;
        drv = 2'b00;
        for (int i = 0; i < 2; i++) begin
            drv = pin_drive(gp_func[i], fo_low[i], next_sw_hold[i] & sw_mode);
            next_pin_out[i] = drv[1];
            next_pin_oe[i] = drv[0];
            // set wins over a software clear in the same cycle
            next_wake[i] = ((gp_func[i] == PIN_WAKE) && wake_mode && (gp_in[i] != gp_d[i]))
                         | (wake_event_status_two[i] & ~wake_event_clear[i]);
            if (live_mode) begin
                next_lvl[i] = (gp_func[i] != PIN_FO) ? gp_in[i] : 1'b0;
            end
        end
        if (live_mode && gp_func[1] == PIN_FO) begin
            next_lvl[1] = strap_level;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_hold <= 2'b00;
            // idle pin level is high, so a wake pin sees no false edge after reset
            gp_d <= 2'b11;
            wake_event_status_two <= 2'b00;
            wake_level_status <= 2'b00;
            pin_out <= 2'b00;
            pin_oe <= 2'b00;
            static_fail_pin_oe <= 1'b0;
        end else begin
            sw_hold <= next_sw_hold;
            gp_d <= next_gp_d;
            wake_event_status_two <= next_wake;
            wake_level_status <= next_lvl;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            static_fail_pin_oe <= next_static_oe;
        end
    end

    // open drain: the static pin only ever pulls low, blink and pwm pins drive high only as high-side switches; released when oe drops
    assign static_fail_pin_out = 1'b0;
    assign blink_fail_pin_out = pin_out[0];
    assign blink_fail_pin_oe = pin_oe[0];
    assign pwm_fail_strap_pin_out = pin_out[1];
    assign pwm_fail_strap_pin_oe = pin_oe[1];

    sequence clear_request;
        (sbc_mode == MODE_NORMAL) && !nonwd_cond && !wd_caused && failure_flag_clear
        && !force_fail_pins_bit && !wd_trig_fail && !undervoltage_event;
    endsequence

    sequence still_quiet;
        (sbc_mode == MODE_NORMAL) && !nonwd_cond && !force_fail_pins_bit
        && !wd_trig_fail && !undervoltage_event;
    endsequence

    sequence uv_fourth;
        undervoltage_event && (uv_cnt == 3'h3);
    endsequence

    wd_sat_a: assert property (@(posedge clk) disable iff (!rst_b)
        (strap_cfg == CFG_TWO) |-> watchdog_error_count <= 2'h1 || $changed(strap_cfg))
        else $error("watchdog error count above its maximum");
    wd_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wd_trig_ok && !wd_trig_fail) |=> watchdog_error_count == 2'h0)
        else $error("watchdog error count not cleared");
    thermal_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
        thermal_shutdown_level_two |=> failure_flag && fail_active)
        else $error("thermal shutdown did not flag failure");
    ov_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        (regulator_overvoltage && regulator_overvoltage_reset_en) |=> fail_active ##1 static_fail_pin_oe)
        else $error("enabled over-voltage did not activate pins");
    force_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
        force_fail_pins_bit |=> ##1 static_fail_pin_oe)
        else $error("force bit did not drive the static pin");
    cfg2_first_a: assert property (@(posedge clk) disable iff (!rst_b)
        (strap_cfg == CFG_TWO && wd_trig_fail && watchdog_error_count == 2'h0
         && !failure_flag && !nonwd_cond && !undervoltage_event) |=> !failure_flag)
        else $error("first watchdog failure set the flag in configuration two");
    uv_four_a: assert property (@(posedge clk) disable iff (!rst_b)
        uv_fourth |=> failure_flag && fail_active && uv_cnt == 3'h0)
        else $error("fourth under-voltage event did not activate pins");
    early_wd_a: assert property (@(posedge clk) disable iff (!rst_b)
        (strap_cfg == CFG_ONE && wd_trig_fail) |=> fail_active && failure_flag)
        else $error("first watchdog failure ignored in configuration one");
    release_a: assert property (@(posedge clk) disable iff (!rst_b)
        clear_request ##1 still_quiet |=> !fail_active)
        else $error("fail pins not released after flag clear");
    sleep_switch_a: assert property (@(posedge clk) disable iff (!rst_b)
        (sbc_mode == MODE_SLEEP && blink_pin_func == PIN_HS) |=> !blink_fail_pin_oe)
        else $error("switch left on in sleep mode");
endmodule : fos_top
`default_nettype wire

/* File: sim/fos_lamp_model.sv */
// fail output signalling: lamps and loads on the three fail pins
// assumes pull-ups to the supply on every pin; ext_low models a load pulling a pin down
`timescale 1ns/1ps
`default_nettype none
module fos_lamp_model (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] ext_low,
    output logic [2:0] pin_lvl
);
    // released pins float up, so the strap pin reads high at power-up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : ~ext_low[i];
        end
    end
endmodule : fos_lamp_model
`default_nettype wire

/* File: sim/fos_top_tb.sv */
// fail output signalling: self-checking testbench
// assumes fos_top with short waveform counts; pins resolved by fos_lamp_model
`timescale 1ns/1ps
`default_nettype none
module fos_top_tb;
    import fos_pkg::*;
    localparam int BH = 20;
    localparam int PP = 80;
    localparam int DIV [4] = '{5, 10, 20, 40};
    logic clk, rst_b, ov_en, uv, uvc, force_on, clr, wdf, wdok, wdoff, wfs;
    logic [1:0] mode, cfg, duty, bfunc, pfunc, sw, wclr;
    logic [2:0] flt, ext, pout, poe, plvl;
    logic flag, act, fsreq, strap;
    logic [1:0] wcnt, wstat, wlvl;
    int error_cnt, tests_run, cb, cp;
    fos_top #(.BLINK_HALF(BH), .PWM_PERIOD(PP)) fos_top_i (
        .clk(clk), .rst_b(rst_b), .sbc_mode(mode), .strap_cfg(cfg), .wd_trig_fail(wdf),
        .wd_trig_ok(wdok), .wd_off_in_stop(wdoff), .wd_failsafe_en(wfs),
        .thermal_shutdown_level_two(flt[0]), .regulator_short(flt[1]),
        .regulator_overvoltage(flt[2]), .regulator_overvoltage_reset_en(ov_en),
        .undervoltage_event(uv), .undervoltage_run_clear(uvc), .force_fail_pins_bit(force_on),
        .pwm_duty_select(duty), .failure_flag_clear(clr), .blink_pin_func(bfunc),
        .pwm_pin_func(pfunc), .switch_on(sw), .wake_event_clear(wclr),
        .static_fail_pin_in(plvl[0]), .static_fail_pin_out(pout[0]), .static_fail_pin_oe(poe[0]),
        .blink_fail_pin_in(plvl[1]), .blink_fail_pin_out(pout[1]), .blink_fail_pin_oe(poe[1]),
        .pwm_fail_strap_pin_in(plvl[2]), .pwm_fail_strap_pin_out(pout[2]),
        .pwm_fail_strap_pin_oe(poe[2]), .failure_flag(flag), .fail_active(act),
        .failsafe_request(fsreq), .watchdog_error_count(wcnt), .wake_event_status_two(wstat),
        .wake_level_status(wlvl), .strap_level(strap)
    );
    fos_lamp_model fos_lamp_model_i (.pin_out(pout), .pin_oe(poe), .ext_low(ext), .pin_lvl(plvl));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic pls(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask : pls
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask : chk
    // release path shared by every fault case; clear only counts once the cause is gone
    task automatic release_chk();
        pls(clr);
        step(3);
        chk(act, 1'b0, "release");
        chk(poe, 3'h0, "pins released");
    endtask : release_chk
    task automatic hit(input logic [2:0] f, input logic e);
        flt = f;
        step(1);
        chk(flag, e, "fault flag");
        flt = 3'h0;
        release_chk();
    endtask : hit
    task automatic meas(input int n);
        cb = 0;
        cp = 0;
        repeat (n) begin
            step(1);
            cb += int'(poe[1]);
            cp += int'(poe[2]);
        end
    endtask : meas
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #(20000 * 20);
        error_cnt++;
        test_done();
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        rst_b = 1'b0;
        {ov_en, uv, uvc, force_on, clr, wdf, wdok, wdoff, wfs} = 9'h000;
        {flt, ext, sw, wclr} = 10'h000;
        mode = MODE_NORMAL;
        cfg = CFG_ONE;
        duty = DUTY_20;
        bfunc = PIN_FO;
        pfunc = PIN_FO;
        step(5);
        rst_b = 1'b1;
        step(1);
        chk({flag, act, strap}, 3'h1, "reset state");
        flt = 3'h1;
        step(1);
        chk({flag, act, fsreq}, 3'h7, "thermal activation");
        step(1);
        chk(poe, 3'h7, "pins together");
        chk(plvl[0], 1'b0, "static pin low");
        pls(clr);
        step(2);
        chk(flag, 1'b1, "clear with cause present");
        flt = 3'h0;
        release_chk();
        hit(3'h2, 1'b1);
        hit(3'h4, 1'b0);
        ov_en = 1'b1;
        hit(3'h4, 1'b1);
        repeat (3) pls(uv);
        pls(uvc);
        repeat (3) pls(uv);
        chk(act, 1'b0, "broken run");
        pls(uv);
        chk({flag, act}, 2'h3, "fourth under-voltage");
        release_chk();
        force_on = 1'b1;
        step(2);
        chk({flag, poe}, 4'h7, "forced pins");
        for (int d = 0; d < 4; d++) begin
            duty = 2'(d);
            step(PP);
            meas(PP);
            chk(16'(cp), 16'(PP / DIV[d]), "pwm duty");
        end
        chk(16'(cb), 16'(PP / 2), "blink half duty");
        force_on = 1'b0;
        step(3);
        chk(poe, 3'h0, "force off");
        wfs = 1'b1;
        cfg = 2'h2;
        pls(wdf);
        chk({act, wcnt}, 3'h1, "first watchdog_error_count cfg3");
        wdf = 1'b1;
        step(1);
        chk(fsreq, 1'b1, "watchdog_error_count-safe request");
        wdf = 1'b0;
        step(1);
        chk(act, 1'b1, "second watchdog_error_count cfg3");
        pls(wdf);
        chk(wcnt, 2'h2, "count saturates");
        pls(clr);
        step(2);
        chk(act, 1'b1, "count still set");
        pls(wdok);
        release_chk();
        for (int c = 0; c < 2; c++) begin
            cfg = 2'(c);
            pls(wdf);
            chk({act, flag}, (c == 0) ? 2'h3 : 2'h2, "first watchdog_error_count");
            pls(wdf);
            chk({act, flag, wcnt}, (c == 0) ? 4'hE : 4'hD, "second watchdog_error_count");
            pls(wdok);
            release_chk();
        end
        cfg = 2'h2;
        pls(wdf);
        pls(wdoff);
        chk(wcnt, 2'h0, "wd off clears");
        pls(wdf);
        mode = MODE_SLEEP;
        step(2);
        chk(wcnt, 2'h0, "sleep clears");
        mode = MODE_NORMAL;
        bfunc = PIN_WAKE;
        step(2);
        ext[1] = 1'b1;
        step(2);
        chk({wstat[0], wlvl[0]}, 2'h2, "wake event and level");
        wclr = 2'h1;
        step(1);
        wclr = 2'h0;
        step(1);
        chk(wstat[0], 1'b0, "wake cleared");
        pfunc = PIN_LS;
        bfunc = PIN_HS;
        sw = 2'h3;
        step(3);
        chk({poe[2:1], pout[2:1]}, 4'hD, "switches on");
        mode = MODE_STOP;
        step(3);
        chk(poe[2:1], 2'h3, "switch kept in stop");
        mode = MODE_SLEEP;
        step(3);
        chk(poe[2:1], 2'h0, "switch off in sleep");
        mode = MODE_NORMAL;
        {sw, bfunc, pfunc, ext} = 9'h004;
        step(3000);
        chk(strap, 1'b1, "strap filtered");
        step(300);
        chk(strap, 1'b0, "strap settled");
        test_done();
    end
endmodule : fos_top_tb
`default_nettype wire
